// ---- hdl/hsfc_pkg.sv ----
// Function
// [R1] Other fault types never cancel cooling delay
// [R2] Repeat cooling fault restarts delay from zero
// [R3] Delay-running flag high while timer runs
// [R4] Reboot command or lockout ends delay early
// [R5] Host zero writes clear fault log bits
// [R6] On fall, lockout, enable fall clear log
// [R7] Low undervoltage reset clears; release sets undervoltage
// [R8] Present live faults cannot be cleared
// [R9] Automatic retry leaves fault log unchanged
// [R10] Latched fault bit holds gates off
// [R11] Auto-retry fault: live status holds gates off
// [R12] Converter threshold crossings set sticky alarms
// [R13] Tick, energy, memory-write overflows logged sticky
// [R14] Alarms clear by zero write or lockout
// [R15] Enable held low 128ms before turn-on
// [R16] Live enable level shown; change sets flag
// [R17] Enable-changed cleared like faults; fall sets it
// [R18] On bit rise turns gates on undelayed
// [R19] On bit fall: gates off, log cleared
// [R20] Host-set latch-off fault bit turns gates off
// [R21] Current-limit indicator drives second power-good pin
// [R22] General outputs driven from register bits
// [R23] Delay select: 512ms doubling to 65.5s
// [R24] Gates on only when all conditions hold
//
// Constants and carrier types of the fault and on/off control block.
// Assumes a 50 MHz core clock and a decoded register front end on the link clock.
package hsfc_pkg;

  // Register offsets
  localparam logic [7:0] HSFC_SYSTEM_STATUS   = 8'h00;
  localparam logic [7:0] HSFC_PIN_LEVELS      = 8'h02;
  localparam logic [7:0] HSFC_LIVE_FAULTS     = 8'h03;
  localparam logic [7:0] HSFC_FAULT_LOG       = 8'h04;
  localparam logic [7:0] HSFC_ALARM_FIRST     = 8'h05;
  localparam logic [7:0] HSFC_ALARM_LAST      = 8'h09;
  localparam logic [7:0] HSFC_PRIMARY_CONTROL = 8'h0a;
  localparam logic [7:0] HSFC_RETRY_CONTROL   = 8'h0b;
  localparam logic [7:0] HSFC_DELAY_CONFIG    = 8'h0e;
  localparam logic [7:0] HSFC_PG_PIN_CONFIG   = 8'h10;
  localparam logic [7:0] HSFC_PG_PIN_OUTPUT   = 8'h11;
  localparam logic [7:0] HSFC_ANALOG_PIN_CFG  = 8'h12;
  localparam logic [7:0] HSFC_METER_CONTROL   = 8'h84;
  localparam logic [7:0] HSFC_REBOOT_CONTROL  = 8'ha2;
  localparam logic [7:0] HSFC_NV_CONTROL_DEF  = 8'haa;

  // Fault bit positions, shared by live conditions and the fault log
  localparam int HSFC_F_OVERVOLT  = 0;
  localparam int HSFC_F_UNDERVOLT = 1;
  localparam int HSFC_F_OVERCURR  = 2;
  localparam int HSFC_F_PWR_FAIL  = 3;
  localparam int HSFC_F_FET_SHORT = 4;
  localparam int HSFC_F_FET_BAD   = 5;
  localparam int HSFC_F_EXTERNAL  = 6;
  localparam logic [7:0] HSFC_TURN_OFF_MASK = 8'h67;
  localparam logic [7:0] HSFC_COOLING_MASK  = 8'h64;
  localparam logic [7:0] HSFC_RETRY_DLY_MASK = 8'h66;
  localparam logic [7:0] HSFC_LIVE_LOG_MASK = 8'hf7;

  // Field positions
  localparam int HSFC_CTRL_ON      = 3;
  localparam int HSFC_CTRL_CL_IND  = 2;
  localparam int HSFC_COOL_SEL_LSB = 1;
  localparam int HSFC_DELAY_STATUS = 1;
  localparam int HSFC_REBOOT_CMD   = 7;
  localparam int HSFC_EN_CHANGED   = 0;
  localparam int HSFC_EE_WRITTEN   = 1;
  localparam int HSFC_TICK_OVF     = 7;
  localparam int HSFC_METER_OVF    = 6;
  localparam logic [7:0] HSFC_ADC_ALARM1_MASK = 8'hfc;
  localparam logic [7:0] HSFC_METER_OVF_MASK  = 8'hc0;
  localparam int HSFC_SYS_EN_LEVEL = 0;
  localparam int HSFC_SYS_GATE_ON  = 1;
  localparam int HSFC_SYS_PG_LATCH = 2;

  // Reset values
  localparam logic [7:0] HSFC_RST_REG      = 8'h00;
  localparam logic [7:0] HSFC_RST_RETRY    = 8'h7f;
  localparam logic [31:0] HSFC_RST_COUNT   = 32'h0000_0000;

  // Timing
  localparam int HSFC_CLK_HZ        = 50_000_000;
  localparam int HSFC_DEBOUNCE_MS   = 128;
  localparam int HSFC_DEBOUNCE_CYCLES = HSFC_DEBOUNCE_MS * (HSFC_CLK_HZ / 1000);
  localparam int HSFC_DELAY_BASE_MS = 512;
  localparam int HSFC_DELAY_BASE_CYCLES = HSFC_DELAY_BASE_MS * (HSFC_CLK_HZ / 1000);

  typedef struct packed {
    logic       en_n;
    logic       lockout;
    logic       uvl_reset;
    logic       uvl_below;
    logic       uvh_below;
    logic [7:0] live;
    logic [7:0] levels;
  } hsfc_pins_t;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hsfc_req_t;

endpackage

// ---- hdl/hsfc_control.sv ----
// Fault latch, cooling delay, enable debounce and on/off control.
// Register requests arrive decoded on the link clock and cross by toggle handshake;
// analog comparator results and pin levels arrive asynchronous and are synchronised.
`timescale 1ns/10ps

module hsfc_control
  import hsfc_pkg::*;
#(
  parameter logic [31:0] DEBOUNCE_CYCLES   = 32'(HSFC_DEBOUNCE_CYCLES),
  parameter logic [31:0] DELAY_BASE_CYCLES = 32'(HSFC_DELAY_BASE_CYCLES)
)
(
  input  wire logic                ref_clk_in,
  input  wire logic                srst_in,
  input  wire logic                link_clk_in,
  input  wire logic                link_req_in,
  input  wire hsfc_req_t           link_req_data_in,
  output logic                     link_busy_out,
  output logic                     link_done_out,
  output logic [7:0]               link_rdata_out,
  input  wire hsfc_pins_t          pins_in,
  input  wire logic                power_good_latched_in,
  input  wire logic [4:0][7:0]     adc_alarm_in,
  input  wire logic                tick_overflow_in,
  input  wire logic                meter_overflow_in,
  input  wire logic                nv_written_in,
  output logic                     gate_on_out,
  output logic [3:0]               pg_pin_out,
  output logic [3:0]               pg_pin_oe_n_out,
  output logic [3:0]               adio_pin_out,
  output logic [3:0]               adio_pin_oe_n_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter checks

  if (DEBOUNCE_CYCLES == 32'h0000_0000 || DELAY_BASE_CYCLES == 32'h0000_0000)
  begin : g_zero_chk
    $error("hsfc_control: counts must be nonzero");
  end
  if (DELAY_BASE_CYCLES > 32'h01ff_ffff)
  begin : g_range_chk
    $error("hsfc_control: delay base overflows 32 bit timer at top select");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic       req_tog;
    hsfc_req_t  req;
    logic       ack_s1;
    logic       ack_s2;
    logic       ack_prev;
    logic       done;
    logic [7:0] rdata;
  } hsfc_link_t;

  typedef struct packed {
    hsfc_pins_t      s1;
    hsfc_pins_t      s2;
    logic            en_prev;
    logic            uvl_prev;
    logic [7:0]      live_prev;
    logic            req_s1;
    logic            req_s2;
    logic            req_prev;
    logic            ack_tog;
    logic [7:0]      rdata;
    logic [7:0]      fault_log;
    logic [4:0][7:0] alarm_log;
    logic [7:0]      ctrl1;
    logic [7:0]      ctrl2;
    logic [7:0]      cfg2;
    logic [7:0]      pg_cfg;
    logic [7:0]      pg_out;
    logic [7:0]      adio_cfg;
    logic [7:0]      meter;
    logic [7:0]      nv_ctrl;
    logic            delay_run;
    logic [31:0]     dly_cnt;
    logic [31:0]     deb_cnt;
    logic            gate;
  } hsfc_core_t;

  hsfc_link_t lk;
  hsfc_link_t next_lk;
  hsfc_core_t q;
  hsfc_core_t next_q;

  function automatic logic [31:0] hsfc_delay_target(input logic [2:0] sel);
    hsfc_delay_target = DELAY_BASE_CYCLES << sel;  // [R23]
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: request capture and answer pickup

  always_comb
  begin
    next_lk          = lk;
    next_lk.ack_s1   = q.ack_tog;
    next_lk.ack_s2   = lk.ack_s1;
    next_lk.ack_prev = lk.ack_s2;
    next_lk.done     = lk.ack_s2 ^ lk.ack_prev;
    // Core holds its answer until the next request, so it is stable here
    if (lk.ack_s2 ^ lk.ack_prev)
    begin
      next_lk.rdata = q.rdata;
    end
    if (link_req_in && !link_busy_out)
    begin
      next_lk.req     = link_req_data_in;
      next_lk.req_tog = ~lk.req_tog;
    end
  end

  always_ff @(posedge link_clk_in)
  begin
    if (srst_in)
    begin
      lk <= '0;
    end
    else
    begin
      lk <= next_lk;
    end
  end

  // Busy spans the gap until done, so no request lands before the answer is picked up
  assign link_busy_out  = (lk.req_tog != lk.ack_prev) || lk.done;
  assign link_done_out  = lk.done;
  assign link_rdata_out = lk.rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Core domain

  logic       en_lvl;
  logic       lockout;
  logic       uvl_rst;
  logic [7:0] live;
  logic       req_new;
  logic       wr;
  logic       on_fall;
  logic       reboot;
  logic       en_ok;
  logic       block;
  logic       cool_evt;
  logic       retry_evt;
  logic [7:0] sets;
  logic [7:0] idx;

  always_comb
  begin
    next_q    = q;
    on_fall   = 1'b0;
    reboot    = 1'b0;
    idx       = 8'h00;
    en_lvl    = q.s2.en_n;
    lockout   = q.s2.lockout;
    uvl_rst   = q.s2.uvl_reset;
    live      = q.s2.live;
    next_q.s1 = pins_in;
    next_q.s2 = q.s1;
    next_q.en_prev   = en_lvl;
    next_q.uvl_prev  = uvl_rst;
    next_q.live_prev = live;
    next_q.req_s1    = lk.req_tog;
    next_q.req_s2    = q.req_s1;
    next_q.req_prev  = q.req_s2;
    req_new = q.req_s2 ^ q.req_prev;
    wr      = req_new & lk.req.we;

    // Register access
    if (req_new)
    begin
      next_q.ack_tog = ~q.ack_tog;
    end
    if (wr)
    begin
      if (lk.req.addr == HSFC_FAULT_LOG)
      begin
        next_q.fault_log = lk.req.wdata;  // [R5] [R20]
      end
      else if (lk.req.addr >= HSFC_ALARM_FIRST && lk.req.addr <= HSFC_ALARM_LAST)
      begin
        idx = lk.req.addr - HSFC_ALARM_FIRST;
        next_q.alarm_log[idx[2:0]] = q.alarm_log[idx[2:0]] & lk.req.wdata;  // [R14]
      end
      else if (lk.req.addr == HSFC_PRIMARY_CONTROL)
      begin
        next_q.ctrl1 = lk.req.wdata;
        on_fall = q.ctrl1[HSFC_CTRL_ON] & ~lk.req.wdata[HSFC_CTRL_ON];
      end
      else if (lk.req.addr == HSFC_RETRY_CONTROL)
      begin
        next_q.ctrl2 = lk.req.wdata;
      end
      else if (lk.req.addr == HSFC_DELAY_CONFIG)
      begin
        next_q.cfg2 = lk.req.wdata;
      end
      else if (lk.req.addr == HSFC_PG_PIN_CONFIG)
      begin
        next_q.pg_cfg = lk.req.wdata;
      end
      else if (lk.req.addr == HSFC_PG_PIN_OUTPUT)
      begin
        next_q.pg_out = lk.req.wdata;
      end
      else if (lk.req.addr == HSFC_ANALOG_PIN_CFG)
      begin
        next_q.adio_cfg = lk.req.wdata;
      end
      else if (lk.req.addr == HSFC_METER_CONTROL)
      begin
        next_q.meter = (lk.req.wdata & ~HSFC_METER_OVF_MASK)
                     | (q.meter & lk.req.wdata & HSFC_METER_OVF_MASK);  // [R14]
      end
      else if (lk.req.addr == HSFC_REBOOT_CONTROL)
      begin
        reboot = lk.req.wdata[HSFC_REBOOT_CMD];
      end
      else if (lk.req.addr == HSFC_NV_CONTROL_DEF)
      begin
        next_q.nv_ctrl = lk.req.wdata;
      end
    end
    else if (req_new)
    begin
      if (lk.req.addr == HSFC_SYSTEM_STATUS)
      begin
        next_q.rdata = {5'h00, power_good_latched_in, q.gate, en_lvl};  // [R16]
      end
      else if (lk.req.addr == HSFC_PIN_LEVELS)
      begin
        next_q.rdata = q.s2.levels;
      end
      else if (lk.req.addr == HSFC_LIVE_FAULTS)
      begin
        next_q.rdata = live;
      end
      else if (lk.req.addr == HSFC_FAULT_LOG)
      begin
        next_q.rdata = q.fault_log;
      end
      else if (lk.req.addr >= HSFC_ALARM_FIRST && lk.req.addr <= HSFC_ALARM_LAST)
      begin
        idx = lk.req.addr - HSFC_ALARM_FIRST;
        next_q.rdata = q.alarm_log[idx[2:0]];
      end
      else if (lk.req.addr == HSFC_PRIMARY_CONTROL)
      begin
        next_q.rdata = q.ctrl1;
      end
      else if (lk.req.addr == HSFC_RETRY_CONTROL)
      begin
        next_q.rdata = q.ctrl2;
      end
      else if (lk.req.addr == HSFC_DELAY_CONFIG)
      begin
        next_q.rdata = q.cfg2;
      end
      else if (lk.req.addr == HSFC_PG_PIN_CONFIG)
      begin
        next_q.rdata = q.pg_cfg;
      end
      else if (lk.req.addr == HSFC_PG_PIN_OUTPUT)
      begin
        next_q.rdata = q.pg_out;
      end
      else if (lk.req.addr == HSFC_ANALOG_PIN_CFG)
      begin
        next_q.rdata = q.adio_cfg;
      end
      else if (lk.req.addr == HSFC_METER_CONTROL)
      begin
        next_q.rdata = q.meter;
      end
      else if (lk.req.addr == HSFC_REBOOT_CONTROL)
      begin
        next_q.rdata = 8'({q.delay_run, 1'b0});  // [R3]
      end
      else if (lk.req.addr == HSFC_NV_CONTROL_DEF)
      begin
        next_q.rdata = q.nv_ctrl;
      end
      else
      begin
        next_q.rdata = 8'h00;
      end
    end

    // Fault log; retry attempts never touch it
    sets = (live & HSFC_LIVE_LOG_MASK);  // [R8] [R9]
    sets[HSFC_F_PWR_FAIL] = live[HSFC_F_PWR_FAIL] & power_good_latched_in;
    sets[HSFC_F_UNDERVOLT] = live[HSFC_F_UNDERVOLT]
                           | (q.uvl_prev & ~uvl_rst & q.s2.uvl_below & q.s2.uvh_below);  // [R7]
    if (on_fall || (q.en_prev && !en_lvl))
    begin
      next_q.fault_log = 8'h00;  // [R6] [R19]
    end
    next_q.fault_log = next_q.fault_log | sets;  // [R8]
    // Lockout and undervoltage reset dominate every set
    if (lockout || uvl_rst)
    begin
      next_q.fault_log = 8'h00;  // [R6] [R7]
    end

    // Alarm logs
    if (on_fall || uvl_rst)
    begin
      next_q.alarm_log[0][HSFC_EN_CHANGED] = 1'b0;  // [R17] [R19]
    end
    next_q.alarm_log[0] = next_q.alarm_log[0] | (adc_alarm_in[0] & HSFC_ADC_ALARM1_MASK);  // [R12]
    for (int i = 1; i < 5; i++)
    begin
      next_q.alarm_log[i] = next_q.alarm_log[i] | adc_alarm_in[i];  // [R12]
    end
    next_q.alarm_log[0][HSFC_EN_CHANGED] = next_q.alarm_log[0][HSFC_EN_CHANGED]
                                         | (q.en_prev ^ en_lvl);  // [R16] [R17]
    next_q.alarm_log[0][HSFC_EE_WRITTEN] = next_q.alarm_log[0][HSFC_EE_WRITTEN]
                                         | nv_written_in;  // [R13]
    next_q.meter[HSFC_TICK_OVF]  = next_q.meter[HSFC_TICK_OVF] | tick_overflow_in;  // [R13]
    next_q.meter[HSFC_METER_OVF] = next_q.meter[HSFC_METER_OVF] | meter_overflow_in;  // [R13]
    if (lockout)
    begin
      next_q.alarm_log = '0;  // [R14]
      next_q.meter     = next_q.meter & ~HSFC_METER_OVF_MASK;
    end

    // Cooling and retry delay
    cool_evt  = |(live & ~q.live_prev & HSFC_COOLING_MASK);
    retry_evt = |(q.fault_log & ~next_q.fault_log & HSFC_RETRY_DLY_MASK & ~q.ctrl2);
    if (reboot || lockout)
    begin
      next_q.delay_run = 1'b0;  // [R4]
      next_q.dly_cnt   = HSFC_RST_COUNT;
    end
    else if (cool_evt || retry_evt)
    begin
      next_q.delay_run = 1'b1;  // [R2] [R3]
      next_q.dly_cnt   = HSFC_RST_COUNT;
    end
    else if (q.delay_run)
    begin
      // Other faults do not reach this timer
      if (q.dly_cnt >= hsfc_delay_target(q.cfg2[HSFC_COOL_SEL_LSB +: 3]) - 32'h1)
      begin
        next_q.delay_run = 1'b0;  // [R1] [R3]
      end
      else
      begin
        next_q.dly_cnt = q.dly_cnt + 32'h1;
      end
    end

    // Enable debounce restarts on any high sample
    if (en_lvl)
    begin
      next_q.deb_cnt = HSFC_RST_COUNT;
    end
    else if (q.deb_cnt != DEBOUNCE_CYCLES)
    begin
      next_q.deb_cnt = q.deb_cnt + 32'h1;  // [R15]
    end
    en_ok = (q.deb_cnt == DEBOUNCE_CYCLES) & ~en_lvl;  // [R15]

    // Retry enabled: live status blocks; disabled: the logged bit blocks
    block = |(HSFC_TURN_OFF_MASK & ((q.ctrl2 & live) | (~q.ctrl2 & q.fault_log)));  // [R10] [R11] [R20]
    next_q.gate = next_q.ctrl1[HSFC_CTRL_ON] & en_ok & ~block
                & ~q.delay_run & ~lockout;  // [R18] [R19] [R24]
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      q       <= '0;
      q.ctrl2 <= HSFC_RST_RETRY;
      q.en_prev <= 1'b1;
      q.s1.en_n <= 1'b1;
      q.s2.en_n <= 1'b1;
    end
    else
    begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb
  begin
    gate_on_out       = q.gate;
    pg_pin_out        = q.pg_out[7:4];  // [R22]
    pg_pin_oe_n_out   = ~q.pg_cfg[3:0];
    adio_pin_out      = q.adio_cfg[3:0];  // [R22]
    adio_pin_oe_n_out = ~q.adio_cfg[7:4];
    if (q.ctrl1[HSFC_CTRL_CL_IND])
    begin
      // Open drain: pulled low in startup or current limit, else released
      pg_pin_out[1]      = 1'b0;  // [R21]
      pg_pin_oe_n_out[1] = power_good_latched_in & ~live[HSFC_F_OVERCURR];  // [R21]
    end
  end

endmodule

// ---- sim/hsfc_control_props.sv ----
// Port assertions for the fault and on/off control block.
// Assumes it is bound into hsfc_control; both domains share srst_in.
`timescale 1ns/10ps

module hsfc_control_props
  import hsfc_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       srst_in,
  input wire logic       link_clk_in,
  input wire logic       link_req_in,
  input wire logic       link_busy_out,
  input wire logic       link_done_out,
  input wire logic [7:0] link_rdata_out,
  input wire hsfc_pins_t pins_in,
  input wire logic       gate_on_out,
  input wire logic [3:0] pg_pin_oe_n_out,
  input wire logic [3:0] adio_pin_oe_n_out
);
  ////////////////////////////////////////////////////////////////////////////////
  reset_gate_off_a:
    assert property (@(posedge ref_clk_in) srst_in |=> !gate_on_out)
    else $error("gate on after reset");
  lockout_gate_off_a:
    assert property (@(posedge ref_clk_in) disable iff (srst_in)
      pins_in.lockout [*4] |-> !gate_on_out) else $error("gate on in lockout");
  enable_high_off_a:
    assert property (@(posedge ref_clk_in) disable iff (srst_in)
      pins_in.en_n [*4] |-> !gate_on_out) else $error("gate on with enable high");
  pins_released_a:
    assert property (@(posedge ref_clk_in) srst_in |=>
      (&pg_pin_oe_n_out) && (&adio_pin_oe_n_out)) else $error("pin driven after reset");
  ////////////////////////////////////////////////////////////////////////////////
  // Link handshake: a lost request would hang the host, so the answer is bounded
  take_sets_busy_a:
    assert property (@(posedge link_clk_in) disable iff (srst_in)
      link_req_in && !link_busy_out |=> link_busy_out) else $error("request not taken");
  answer_bound_a:
    assert property (@(posedge link_clk_in) disable iff (srst_in)
      link_req_in && !link_busy_out |-> ##[1:20] link_done_out) else $error("no answer");
  done_single_a:
    assert property (@(posedge link_clk_in) disable iff (srst_in)
      link_done_out |=> !link_done_out && !link_busy_out) else $error("done not a pulse");
  rdata_hold_a:
    assert property (@(posedge link_clk_in) disable iff (srst_in)
      $changed(link_rdata_out) |-> link_done_out) else $error("read data moved");
  gate_rise_c: cover property (@(posedge ref_clk_in) $rose(gate_on_out));
  lockout_c: cover property (@(posedge ref_clk_in) pins_in.lockout && !srst_in);
  answer_c: cover property (@(posedge link_clk_in) link_done_out && link_rdata_out != 8'h00);
endmodule

bind hsfc_control hsfc_control_props u_props (
  .ref_clk_in        (ref_clk_in),
  .srst_in           (srst_in),
  .link_clk_in       (link_clk_in),
  .link_req_in       (link_req_in),
  .link_busy_out     (link_busy_out),
  .link_done_out     (link_done_out),
  .link_rdata_out    (link_rdata_out),
  .pins_in           (pins_in),
  .gate_on_out       (gate_on_out),
  .pg_pin_oe_n_out   (pg_pin_oe_n_out),
  .adio_pin_oe_n_out (adio_pin_oe_n_out)
);

// ---- sim/hsfc_host_model.sv ----
// Host side of the register link: one decoded request at a time.
// Assumes the bench supplies the link clock and waits out reset first.
`timescale 1ns/10ps

module hsfc_host_model
  import hsfc_pkg::*;
(
  input  wire logic       link_clk_in,
  input  wire logic       link_busy_in,
  input  wire logic       link_done_in,
  input  wire logic [7:0] link_rdata_in,
  output hsfc_req_t       req_data_out,
  output logic            req_out
);
  initial
  begin
    req_out      = 1'b0;
    req_data_out = '0;
  end

  // Qualifiers stay put until done or 20 link cycles pass; then inverted so stale data is never trusted
  task automatic xfer(input logic we, input logic [7:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    int n;
    rdata = 8'hxx;
    @(posedge link_clk_in);
    while (link_busy_in !== 1'b0)
      @(posedge link_clk_in);
    req_out      <= 1'b1;
    req_data_out <= '{we: we, addr: addr, wdata: wdata};
    @(posedge link_clk_in);
    req_out <= 1'b0;
    n = 0;
    while (link_done_in !== 1'b1 && n < 20)
    begin
      @(posedge link_clk_in);
      n++;
    end
    if (link_done_in === 1'b1)
      rdata = link_rdata_in;
    req_data_out <= ~req_data_out;
  endtask
endmodule

// ---- sim/test_hsfc_control.sv ----
// Self-checking bench for the fault and on/off control block.
// Assumes shortened debounce and delay counts; registers reached via the host model.
`timescale 1ns/10ps

module test_hsfc_control
  import hsfc_pkg::*;
;
  logic             ref_clk_in = 1'b0;
  logic             link_clk_in = 1'b0;
  logic             srst_in = 1'b1;
  logic             link_req_in;
  hsfc_req_t        link_req_data_in;
  logic             link_busy_out;
  logic             link_done_out;
  logic [7:0]       link_rdata_out;
  hsfc_pins_t       pins_in = '{en_n: 1'b1, levels: 8'h3c, default: '0};
  logic             power_good_latched_in = 1'b0;
  logic [4:0][7:0]  adc_alarm_in = '0;
  logic             tick_overflow_in = 1'b0;
  logic             meter_overflow_in = 1'b0;
  logic             nv_written_in = 1'b0;
  logic             gate_on_out;
  logic [3:0]       pg_pin_out;
  logic [3:0]       pg_pin_oe_n_out;
  logic [3:0]       adio_pin_out;
  logic [3:0]       adio_pin_oe_n_out;
  int               num_errors = 0;
  int               samples_checked = 0;

  always #10 ref_clk_in = ~ref_clk_in;
  always #3 link_clk_in = ~link_clk_in;

  // Short counts: debounce 20 cycles, delay base 8 cycles (select 3 gives 64)
  hsfc_control #(.DEBOUNCE_CYCLES(32'h14), .DELAY_BASE_CYCLES(32'h8)) u_dut (
    .ref_clk_in (ref_clk_in), .srst_in (srst_in), .link_clk_in (link_clk_in),
    .link_req_in (link_req_in), .link_req_data_in (link_req_data_in),
    .link_busy_out (link_busy_out), .link_done_out (link_done_out),
    .link_rdata_out (link_rdata_out), .pins_in (pins_in),
    .power_good_latched_in (power_good_latched_in), .adc_alarm_in (adc_alarm_in),
    .tick_overflow_in (tick_overflow_in), .meter_overflow_in (meter_overflow_in),
    .nv_written_in (nv_written_in), .gate_on_out (gate_on_out), .pg_pin_out (pg_pin_out),
    .pg_pin_oe_n_out (pg_pin_oe_n_out), .adio_pin_out (adio_pin_out),
    .adio_pin_oe_n_out (adio_pin_oe_n_out));

  hsfc_host_model u_host (
    .link_clk_in (link_clk_in), .link_busy_in (link_busy_out), .link_done_in (link_done_out),
    .link_rdata_in (link_rdata_out), .req_data_out (link_req_data_in), .req_out (link_req_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.xfer(1'b1, a, d, q);
    chk("write answer", 8'h01, {7'h00, q !== 8'hxx});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string name);
    logic [7:0] q;
    u_host.xfer(1'b0, a, 8'h00, q);
    chk(name, e, q);
  endtask
  task automatic gt(input logic e);
    chk("gate", {7'h00, e}, {7'h00, gate_on_out});
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(8'h0b, 8'h7f, "retry reset");
    rd(8'h0a, 8'h00, "primary reset");
    wr(8'h30, 8'h5a);
    rd(8'h30, 8'h00, "unmapped");
  endtask
  task automatic t_enable();
    wr(8'h0a, 8'h08);
    cyc(30);
    gt(1'b0);
    pins_in.en_n <= 1'b0;
    cyc(12);
    pins_in.en_n <= 1'b1;
    cyc(2);
    pins_in.en_n <= 1'b0;
    cyc(14);
    gt(1'b0);
    cyc(16);
    gt(1'b1);
    rd(8'h00, 8'h02, "system status");
    rd(8'h05, 8'h01, "enable changed");
  endtask
  task automatic t_retry();
    wr(8'h0e, 8'h06);
    cyc(1);
    pins_in.live[2] <= 1'b1;
    cyc(6);
    gt(1'b0);
    rd(8'ha2, 8'h02, "delay running");
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h04, "log held");
    cyc(1);
    pins_in.live[2] <= 1'b0;
    cyc(20);
    pins_in.live[5] <= 1'b1;
    cyc(2);
    pins_in.live[5] <= 1'b0;
    cyc(12);
    pins_in.live[0] <= 1'b1;
    cyc(2);
    pins_in.live[0] <= 1'b0;
    cyc(36);
    gt(1'b0);
    cyc(25);
    gt(1'b1);
    rd(8'ha2, 8'h00, "delay expired");
    rd(8'h04, 8'h25, "log after retry");
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h00, "log cleared");
  endtask
  task automatic t_latch();
    wr(8'h0b, 8'h7b);
    wr(8'h04, 8'h04);
    cyc(3);
    gt(1'b0);
    cyc(80);
    gt(1'b0);
    wr(8'h04, 8'h00);
    cyc(30);
    gt(1'b0);
    cyc(45);
    gt(1'b1);
    wr(8'h0b, 8'h7f);
    wr(8'h04, 8'h01);
    cyc(4);
    gt(1'b1);
  endtask
  task automatic t_onoff();
    wr(8'h0a, 8'h00);
    cyc(4);
    gt(1'b0);
    rd(8'h04, 8'h00, "log on fall");
    rd(8'h05, 8'h00, "changed on fall");
    wr(8'h0a, 8'h08);
    cyc(3);
    gt(1'b1);
  endtask
  task automatic t_alarm();
    cyc(1);
    adc_alarm_in <= {8'h00, 8'h00, 8'h00, 8'h81, 8'h04};
    {tick_overflow_in, meter_overflow_in, nv_written_in} <= 3'h7;
    cyc(1);
    adc_alarm_in <= '0;
    {tick_overflow_in, meter_overflow_in, nv_written_in} <= 3'h0;
    rd(8'h06, 8'h81, "alarm two");
    rd(8'h05, 8'h06, "alarm first");
    rd(8'h84, 8'hc0, "overflows");
    wr(8'h06, 8'h01);
    rd(8'h06, 8'h01, "alarm zero write");
  endtask
  task automatic t_uvl();
    wr(8'h04, 8'h01);
    cyc(1);
    {pins_in.uvl_reset, pins_in.uvl_below, pins_in.uvh_below} <= 3'h7;
    cyc(3);
    rd(8'h04, 8'h00, "log in uv reset");
    cyc(1);
    pins_in.uvl_reset <= 1'b0;
    cyc(3);
    rd(8'h04, 8'h02, "undervoltage_fault_flag set");
    {pins_in.uvl_below, pins_in.uvh_below} <= 2'h0;
    wr(8'h04, 8'h00);
  endtask
  task automatic t_pins();
    wr(8'h10, 8'h0d);
    wr(8'h11, 8'ha0);
    wr(8'h12, 8'hf5);
    cyc(3);
    chk("pg data", 8'h08, {4'h0, pg_pin_out & 4'hd});
    chk("pg enable", 8'h02, {4'h0, pg_pin_oe_n_out});
    chk("analog pins", 8'h05, {adio_pin_oe_n_out, adio_pin_out});
    wr(8'h0a, 8'h0c);
    cyc(3);
    chk("pin two startup", 8'h00, {6'h00, pg_pin_oe_n_out[1], pg_pin_out[1]});
    power_good_latched_in <= 1'b1;
    cyc(3);
    chk("pin two float", 8'h01, {7'h00, pg_pin_oe_n_out[1]});
    pins_in.live[2] <= 1'b1;
    cyc(4);
    chk("pin two limit", 8'h00, {6'h00, pg_pin_oe_n_out[1], pg_pin_out[1]});
    pins_in.live[2] <= 1'b0;
  endtask
  task automatic t_lockout();
    cyc(1);
    pins_in.live[6] <= 1'b1;
    cyc(4);
    pins_in.live[6] <= 1'b0;
    wr(8'ha2, 8'h80);
    rd(8'ha2, 8'h00, "reboot ends delay");
    pins_in.live[6] <= 1'b1;
    cyc(4);
    pins_in.live[6] <= 1'b0;
    cyc(1);
    pins_in.lockout <= 1'b1;
    cyc(5);
    gt(1'b0);
    pins_in.lockout <= 1'b0;
    rd(8'ha2, 8'h00, "lockout ends delay");
    rd(8'h04, 8'h00, "log in lockout");
    rd(8'h06, 8'h00, "alarm in lockout");
  endtask

  initial
  begin
    repeat (5) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    @(posedge link_clk_in);
    t_regs();
    t_enable();
    t_retry();
    t_latch();
    t_onoff();
    t_alarm();
    t_uvl();
    t_pins();
    t_lockout();
    end_of_test();
  end

  // Whole sequence takes a few hundred core cycles; this span is ample
  initial
  begin
    #400000;
    num_errors++;
    end_of_test();
  end
endmodule
